// *** src/usbirq_ctrl.sv ***
// Interrupt mask, pending status, clear and endpoint FIFO reset registers of the USB device port
`timescale 1ns/100ps
module usbirq_ctrl #(
  parameter int IDLE_CYCLES = usbirq_pkg::SUSPEND_IDLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [usbirq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [usbirq_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [usbirq_pkg::DATA_W-1:0] rd_data_o,
  // Endpoint flag sources from the endpoint control/status logic
  input wire logic [usbirq_pkg::EP_COUNT-1:0] setup_received_i,
  input wire logic [usbirq_pkg::EP_COUNT-1:0] rx_bank_a_full_i,
  input wire logic [usbirq_pkg::EP_COUNT-1:0] rx_bank_b_full_i,
  input wire logic [usbirq_pkg::EP_COUNT-1:0] tx_acknowledged_i,
  input wire logic [usbirq_pkg::EP_COUNT-1:0] stall_acknowledged_i,
  // Bus events from the serial engine, one-cycle pulses apart from bus_activity_i, which can be held as a level
  input wire logic bus_activity_i,
  input wire logic resume_signal_i,
  input wire logic external_resume_i,
  input wire logic sof_pid_i,
  input wire logic bus_reset_start_i,
  input wire logic bus_reset_end_i,
  // Endpoint FIFO side
  output logic [usbirq_pkg::EP_COUNT-1:0] endpoint_reset_bit_o,
  // Device state and interrupt
  output logic suspended_o,
  output logic irq_o
);
  import usbirq_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [EVENT_W-1:0] irq_mask;
  logic [EVENT_W-1:0] mask_view;
  logic [EP_COUNT-1:0] endpoint_event;
  logic [EP_COUNT-1:0] next_endpoint_event;
  logic [EVENT_W-1:EP_COUNT] bus_event;
  logic [EVENT_W-1:EP_COUNT] bus_event_set;
  logic [EVENT_W-1:EP_COUNT] bus_event_clr;
  logic [EVENT_W-1:0] pending_view;
  logic [EP_COUNT-1:0] endpoint_fifo_reset;
  logic [DATA_W-1:0] next_rd_data;
  logic suspend_event;
  logic wr_set;
  logic wr_disable;
  logic wr_clear;
  logic wr_ep_reset;

  // Full-address match, shared by the write and read decoders
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    addr_hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Suspend detection
  // ----------------------------------------------------------------
  usbirq_idle_timer #(
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_idle_timer (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .bus_activity_i(bus_activity_i),
    .suspend_start_o(suspend_event),
    .suspended_o(suspended_o)
  );

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_set = wr_en_i && addr_hit(addr_i, ADDR_IRQ_ENABLE_SET);
  assign wr_disable = wr_en_i && addr_hit(addr_i, ADDR_IRQ_ENABLE_CLEAR);
  assign wr_clear = wr_en_i && addr_hit(addr_i, ADDR_IRQ_CLEAR);
  assign wr_ep_reset = wr_en_i && addr_hit(addr_i, ADDR_ENDPOINT_FIFO_RESET);

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  // Only reachable through set/disable writes; the view itself is read-only
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      irq_mask <= MASK_RESET;
    end else if (wr_set) begin
      irq_mask <= irq_mask | (wr_data_i[EVENT_W-1:0] & MASK_WRITABLE);
    end else if (wr_disable) begin
      irq_mask <= irq_mask & ~(wr_data_i[EVENT_W-1:0] & MASK_WRITABLE);
    end
  end

  // The forced position always reads as one, whatever is stored, so the bus-reset-done event always reaches the output
  assign mask_view = irq_mask | MASK_FORCED;

  // ----------------------------------------------------------------
  // Endpoint pending bits
  // ----------------------------------------------------------------
  // Level copies of the endpoint flags; they fall only when the flag is cleared at its source
  genvar ep;
  generate
    for (ep = 0; ep < EP_COUNT; ep++) begin : g_ep
      assign next_endpoint_event[ep] = setup_received_i[ep] | rx_bank_a_full_i[ep] | rx_bank_b_full_i[ep]
                                     | tx_acknowledged_i[ep] | stall_acknowledged_i[ep];
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      endpoint_event <= '0;
    end else begin
      endpoint_event <= next_endpoint_event;
    end
  end

  // ----------------------------------------------------------------
  // Bus event pending bits
  // ----------------------------------------------------------------
  // Set sources per position
  always_comb begin
    bus_event_set = '0;
    bus_event_set[SUSPEND_POS] = suspend_event;
    bus_event_set[RESUME_POS] = resume_signal_i;
    bus_event_set[EXT_RESUME_POS] = external_resume_i;
    bus_event_set[FRAME_START_POS] = sof_pid_i;
    bus_event_set[BUS_RESET_DONE_POS] = bus_reset_end_i;
    bus_event_set[WAKEUP_POS] = resume_signal_i | bus_reset_start_i;
  end

  // Endpoint positions are outside the clearable group, so ones there do nothing
  assign bus_event_clr = wr_clear ? (wr_data_i[EVENT_W-1:EP_COUNT] & CLEARABLE[EVENT_W-1:EP_COUNT])
                                  : '0;

  // A set in the same cycle as a clear wins, so no event is lost
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      bus_event <= PENDING_RESET[EVENT_W-1:EP_COUNT];
    end else begin
      bus_event <= (bus_event & ~bus_event_clr) | bus_event_set;
    end
  end

  assign pending_view = {bus_event, endpoint_event};

  // ----------------------------------------------------------------
  // Endpoint FIFO reset register
  // ----------------------------------------------------------------
  // Held for as long as software leaves the bit set; no self-clearing
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      endpoint_fifo_reset <= EP_RESET_RESET;
    end else if (wr_ep_reset) begin
      endpoint_fifo_reset <= wr_data_i[EP_COUNT-1:0];
    end
  end

  // Drives FIFO pointer, byte count and toggle clears only; control/status flags never see it
  assign endpoint_reset_bit_o = endpoint_fifo_reset;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Write-only and unmapped addresses read as zero
  always_comb begin
    next_rd_data = READ_IDLE;
    if (addr_hit(addr_i, ADDR_IRQ_MASK_VIEW)) begin
      next_rd_data[EVENT_W-1:0] = mask_view;
    end else if (addr_hit(addr_i, ADDR_IRQ_PENDING_VIEW)) begin
      next_rd_data[EVENT_W-1:0] = pending_view;
    end else if (addr_hit(addr_i, ADDR_ENDPOINT_FIFO_RESET)) begin
      next_rd_data[EP_COUNT-1:0] = endpoint_fifo_reset;
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || !rd_en_i) begin
      rd_data_o <= READ_IDLE;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Registered for a clean output; costs one cycle after the pending bit
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(pending_view & mask_view);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  chk_mask_forced_one: assert property (mask_view[BUS_RESET_DONE_POS])
    else $error("forced mask position reads zero");

  chk_mask_set_write: assert property (wr_set |=> ((irq_mask & $past(wr_data_i[EVENT_W-1:0]) & MASK_WRITABLE)
                                          == ($past(wr_data_i[EVENT_W-1:0]) & MASK_WRITABLE)))
    else $error("enable write did not set mask bits");

  chk_mask_disable_write: assert property (wr_disable |=> ((irq_mask & $past(wr_data_i[EVENT_W-1:0])
                                              & MASK_WRITABLE) == '0))
    else $error("disable write did not clear mask bits");

  chk_mask_zero_keeps: assert property ((wr_set || wr_disable) && wr_data_i[EVENT_W-1:0] == '0
                                        |=> $stable(irq_mask))
    else $error("zero write changed the mask");

  chk_ep_follows_flags: assert property (##1 endpoint_event == $past(setup_received_i | rx_bank_a_full_i
    | rx_bank_b_full_i | tx_acknowledged_i | stall_acknowledged_i))
    else $error("endpoint pending bit does not track its flags");

  chk_sof_sets_pending: assert property (sof_pid_i |=> bus_event[FRAME_START_POS])
    else $error("start of frame not latched");

  chk_set_beats_clear: assert property (resume_signal_i && bus_event_clr[RESUME_POS]
                                        |=> bus_event[RESUME_POS] && bus_event[WAKEUP_POS])
    else $error("resume event lost against a clear");

  chk_clear_drops_bit: assert property (wr_clear && wr_data_i[BUS_RESET_DONE_POS] && !bus_reset_end_i
                                        |=> !bus_event[BUS_RESET_DONE_POS])
    else $error("clear write left bus-reset-done pending");

  chk_wakeup_holds: assert property (bus_event[WAKEUP_POS] && !bus_event_clr[WAKEUP_POS]
                                     |=> bus_event[WAKEUP_POS])
    else $error("wakeup pending dropped without a clear");

  chk_irq_follows: assert property (##1 irq_o == $past(|(pending_view & mask_view)))
    else $error("interrupt output disagrees with pending and mask");

  chk_read_one_cycle: assert property (!rd_en_i |=> rd_data_o == READ_IDLE)
    else $error("read data outside the answer cycle");

  chk_ep_reset_holds: assert property (!wr_ep_reset |=> $stable(endpoint_reset_bit_o))
    else $error("endpoint reset changed without a write");

  // Every bus event reaches its pending bit at the next edge
  chk_suspend_sets_pending: assert property (suspend_event |=> bus_event[SUSPEND_POS])
    else $error("suspend event not latched");

  chk_resume_sets_pending: assert property (resume_signal_i |=> bus_event[RESUME_POS])
    else $error("resume event not latched");

  chk_resume_wakes: assert property (resume_signal_i |=> bus_event[WAKEUP_POS])
    else $error("resume did not set wakeup pending");

  chk_ext_resume_sets: assert property (external_resume_i |=> bus_event[EXT_RESUME_POS])
    else $error("external resume not latched");

  chk_reset_end_sets: assert property (bus_reset_end_i |=> bus_event[BUS_RESET_DONE_POS])
    else $error("end of bus reset not latched");

  chk_reset_start_wakeup: assert property (bus_reset_start_i |=> bus_event[WAKEUP_POS])
    else $error("host reset did not set wakeup pending");

  // Zero bits of a clear write must leave pending state alone
  chk_clear_zero_keeps: assert property (wr_clear && wr_data_i[EVENT_W-1:EP_COUNT] == '0
    |=> bus_event == ($past(bus_event) | $past(bus_event_set)))
    else $error("zero clear write dropped a pending bit");

  // Register port: stored state moves only on its own writes, reads show it
  chk_mask_no_write: assert property (!(wr_set || wr_disable) |=> $stable(irq_mask))
    else $error("mask changed without an enable or disable write");

  chk_ep_reset_write: assert property (wr_ep_reset |=> endpoint_reset_bit_o == $past(wr_data_i[EP_COUNT-1:0]))
    else $error("endpoint reset write not taken");

  chk_read_mask_data: assert property (rd_en_i && addr_i == ADDR_IRQ_MASK_VIEW
    |=> rd_data_o == DATA_W'($past(mask_view)))
    else $error("mask view read returned wrong data");

  chk_read_pending_data: assert property (rd_en_i && addr_i == ADDR_IRQ_PENDING_VIEW
    |=> rd_data_o == DATA_W'($past(pending_view)))
    else $error("pending view read returned wrong data");

  cov_suspend_seen: cover property (suspend_event ##1 bus_event[SUSPEND_POS]);
  cov_irq_raised: cover property (!irq_o ##1 irq_o);
  cov_ep_reset_cycle: cover property (endpoint_reset_bit_o[0] ##[1:8] !endpoint_reset_bit_o[0]);
  cov_clear_and_set: cover property (sof_pid_i && bus_event_clr[FRAME_START_POS]);

endmodule

// *** src/usbirq_pkg.sv ***
// Package of offsets, field positions, reset values and timing for the USB interrupt block
package usbirq_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int EP_COUNT = 8;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int EVENT_W = 14;
  localparam int IDLE_CNT_W = 20;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_SET = 32'h4003_4010;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_CLEAR = 32'h4003_4014;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK_VIEW = 32'h4003_4018;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_PENDING_VIEW = 32'h4003_401c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 32'h4003_4020;
  localparam logic [ADDR_W-1:0] ADDR_ENDPOINT_FIFO_RESET = 32'h4003_4028;

  // ----------------------------------------------------------------
  // Field positions in mask, pending and clear registers
  // ----------------------------------------------------------------
  localparam int SUSPEND_POS = 8;
  localparam int RESUME_POS = 9;
  localparam int EXT_RESUME_POS = 10;
  localparam int FRAME_START_POS = 11;
  localparam int BUS_RESET_DONE_POS = 12;
  localparam int WAKEUP_POS = 13;

  // ----------------------------------------------------------------
  // Field groups and reset values
  // ----------------------------------------------------------------
  localparam logic [EVENT_W-1:0] MASK_WRITABLE = 14'h2fff;
  localparam logic [EVENT_W-1:0] MASK_FORCED = 14'h1000;
  localparam logic [EVENT_W-1:0] MASK_RESET = 14'h0200;
  localparam logic [EVENT_W-1:0] CLEARABLE = 14'h3f00;
  localparam logic [EVENT_W-1:0] PENDING_RESET = 14'h0000;
  localparam logic [EP_COUNT-1:0] EP_RESET_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SUSPEND_IDLE_MS = 3;
  localparam int SUSPEND_IDLE_CYCLES = SUSPEND_IDLE_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Bus link state
  // ----------------------------------------------------------------
  typedef enum logic {
    USBIRQ_LINK_ACTIVE,
    USBIRQ_LINK_SUSPENDED
  } usbirq_link_e;

endpackage

// *** src/usbirq_idle_timer.sv ***
// Idle detector that raises a suspend event after a quiet bus period
`timescale 1ns/100ps
module usbirq_idle_timer #(
  parameter int IDLE_CYCLES = usbirq_pkg::SUSPEND_IDLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Bus side
  input wire logic bus_activity_i,
  // Results
  output logic suspend_start_o,
  output logic suspended_o
);
  import usbirq_pkg::*;

  localparam logic [IDLE_CNT_W-1:0] IDLE_LAST = IDLE_CNT_W'(IDLE_CYCLES - 1);

  usbirq_link_e link_state;
  usbirq_link_e next_link_state;
  logic [IDLE_CNT_W-1:0] idle_count;
  logic idle_done;

  // Terminal count reached while no traffic is seen
  assign idle_done = (idle_count == IDLE_LAST) && !bus_activity_i;

  // Quiet-time counter, restarted by any traffic
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || bus_activity_i || link_state == USBIRQ_LINK_SUSPENDED) begin
      idle_count <= '0;
    end else if (!idle_done) begin
      idle_count <= idle_count + IDLE_CNT_W'(1);
    end
  end

  // Link state: suspend on idle, wake on any traffic
  always_comb begin
    next_link_state = link_state;
    case (link_state)
      USBIRQ_LINK_ACTIVE: begin
        if (idle_done) begin
          next_link_state = USBIRQ_LINK_SUSPENDED;
        end
      end
      USBIRQ_LINK_SUSPENDED: begin
        if (bus_activity_i) begin
          next_link_state = USBIRQ_LINK_ACTIVE;
        end
      end
      default: next_link_state = USBIRQ_LINK_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      link_state <= USBIRQ_LINK_ACTIVE;
    end else begin
      link_state <= next_link_state;
    end
  end

  // Outputs registered so the parent sees clean levels
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      suspend_start_o <= 1'b0;
      suspended_o <= 1'b0;
    end else begin
      suspend_start_o <= (link_state == USBIRQ_LINK_ACTIVE) && idle_done;
      suspended_o <= (next_link_state == USBIRQ_LINK_SUSPENDED);
    end
  end

endmodule

// *** verif/usbirq_host_model.sv ***
// Behavioural far side: serial engine events that the host causes on the bus
`timescale 1ns/100ps
module usbirq_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Bus events towards the interrupt block
  output logic bus_activity_o,
  output logic resume_signal_o,
  output logic external_resume_o,
  output logic sof_pid_o,
  output logic bus_reset_start_o,
  output logic bus_reset_end_o
);
  logic [4:0] ev = 5'h00;
  logic busy = 1'b1;

  // Event order: resume, external resume, frame start, reset start, reset end
  assign {bus_reset_end_o, bus_reset_start_o, sof_pid_o, external_resume_o, resume_signal_o} = ev;
  // Any event is traffic too, so the idle timer never sees a quiet event
  assign bus_activity_o = busy | (|ev);

  // One-cycle pulse, the way the host's resume or reset reaches the device
  task automatic pulse(input int idx);
    @(posedge clk_sys_i);
    ev[idx] <= 1'b1;
    @(posedge clk_sys_i);
    ev <= 5'h00;
  endtask

  // Host stops or restarts all traffic
  task automatic go_quiet(input logic q);
    @(posedge clk_sys_i);
    busy <= ~q;
  endtask
endmodule

// *** verif/usb_device_irq_and_ep_reset_tb_top.sv ***
// Self-checking testbench of the USB interrupt and endpoint reset block
`timescale 1ns/100ps
module usb_device_irq_and_ep_reset_tb_top;
  import usbirq_pkg::*;
  localparam int IDLE = 16;
  // Pending pattern expected for each host event, in the model's order
  localparam logic [31:0] EXP [5] = '{32'h2200, 32'h0400, 32'h0800, 32'h2000, 32'h1000};
  logic clk_sys_i;
  logic reset_n_i = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] fl [5] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
  logic [31:0] rd_data_o;
  logic [7:0] endpoint_reset_bit_o;
  logic suspended_o;
  logic irq_o;
  logic act, rsm, ext, sof, rst_s, rst_e;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;

  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  usbirq_ctrl #(.IDLE_CYCLES(IDLE)) u_usbirq_ctrl (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr), .wr_data_i(wdata),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data_o),
    .setup_received_i(fl[0]), .rx_bank_a_full_i(fl[1]), .rx_bank_b_full_i(fl[2]),
    .tx_acknowledged_i(fl[3]), .stall_acknowledged_i(fl[4]),
    .bus_activity_i(act), .resume_signal_i(rsm), .external_resume_i(ext), .sof_pid_i(sof),
    .bus_reset_start_i(rst_s), .bus_reset_end_i(rst_e),
    .endpoint_reset_bit_o(endpoint_reset_bit_o), .suspended_o(suspended_o), .irq_o(irq_o));
  usbirq_host_model u_usbirq_host_model (
    .clk_sys_i(clk_sys_i), .bus_activity_o(act), .resume_signal_o(rsm), .external_resume_o(ext),
    .sof_pid_o(sof), .bus_reset_start_o(rst_s), .bus_reset_end_o(rst_e));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // A hang would otherwise never reach the verdict
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    {addr, wdata, wr_en} <= {a, d, 1'b1};
    @(posedge clk_sys_i);
    wr_en <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    {addr, rd_en} <= {a, 1'b1};
    @(posedge clk_sys_i);
    rd_en <= 1'b0;
    #1;
    check(rd_data_o, exp);
  endtask

  // Lets the pending bit and then the registered interrupt land
  task automatic settle;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [31:0] e;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    #1;
    check({24'h0, endpoint_reset_bit_o}, 32'h0);
    rd(ADDR_IRQ_MASK_VIEW, 32'h1200);
    wr(ADDR_IRQ_CLEAR, 32'h3f00);
    rd(ADDR_IRQ_PENDING_VIEW, 32'h0);
    // Mask set, read-only view, clear, unmaskable position
    wr(ADDR_IRQ_ENABLE_SET, 32'hffff_ffff);
    rd(ADDR_IRQ_MASK_VIEW, 32'h3fff);
    wr(ADDR_IRQ_MASK_VIEW, 32'h0);
    rd(ADDR_IRQ_MASK_VIEW, 32'h3fff);
    wr(ADDR_IRQ_ENABLE_CLEAR, 32'h0101);
    rd(ADDR_IRQ_MASK_VIEW, 32'h3efe);
    wr(ADDR_IRQ_ENABLE_CLEAR, 32'hffff_ffff);
    rd(ADDR_IRQ_MASK_VIEW, 32'h1000);
    u_usbirq_host_model.pulse(3);
    settle();
    check({31'h0, irq_o}, 32'h0);
    u_usbirq_host_model.pulse(4);
    settle();
    check({31'h0, irq_o}, 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'h3f00);
    rd(ADDR_IRQ_PENDING_VIEW, 32'h0);
    // Every host event, zero-writes ignored, one-writes clear
    wr(ADDR_IRQ_ENABLE_SET, 32'hffff);
    for (int i = 0; i < 5; i++) begin
      u_usbirq_host_model.pulse(i);
      settle();
      check({31'h0, irq_o}, 32'h1);
      rd(ADDR_IRQ_PENDING_VIEW, EXP[i]);
      wr(ADDR_IRQ_CLEAR, 32'hffff_c0ff);
      rd(ADDR_IRQ_PENDING_VIEW, EXP[i]);
      wr(ADDR_IRQ_CLEAR, 32'h3f00);
      rd(ADDR_IRQ_PENDING_VIEW, 32'h0);
    end
    // Event and clear in one cycle: the event wins
    for (int j = 0; j < 3; j += 2) begin
      fork
        u_usbirq_host_model.pulse(j);
        wr(ADDR_IRQ_CLEAR, 32'h3f00);
      join
      rd(ADDR_IRQ_PENDING_VIEW, EXP[j]);
      wr(ADDR_IRQ_CLEAR, 32'h3f00);
    end
    // Endpoint flags; endpoint 3 masked off
    wr(ADDR_IRQ_ENABLE_CLEAR, 32'h08);
    for (int k = 0; k < 5; k++) begin
      e = 32'h0;
      e[k + 3] = 1'b1;
      @(posedge clk_sys_i);
      fl[k][k + 3] <= 1'b1;
      settle();
      check({31'h0, irq_o}, {31'h0, k != 0});
      rd(ADDR_IRQ_PENDING_VIEW, e);
      wr(ADDR_IRQ_CLEAR, 32'hffff_ffff);
      wr(ADDR_ENDPOINT_FIFO_RESET, 32'hff);
      check({24'h0, endpoint_reset_bit_o}, 32'hff);
      rd(ADDR_IRQ_PENDING_VIEW, e);
      wr(ADDR_ENDPOINT_FIFO_RESET, 32'h0);
      @(posedge clk_sys_i);
      fl[k] <= 8'h0;
      rd(ADDR_IRQ_PENDING_VIEW, 32'h0);
    end
    // Endpoint reset register and refused places
    wr(ADDR_ENDPOINT_FIFO_RESET, 32'hffff_ffa5);
    check({24'h0, endpoint_reset_bit_o}, 32'ha5);
    wr(32'h4003_402c, 32'hff);
    rd(ADDR_ENDPOINT_FIFO_RESET, 32'ha5);
    rd(32'h4003_4024, 32'h0);
    rd(ADDR_IRQ_CLEAR, 32'h0);
    wr(ADDR_ENDPOINT_FIFO_RESET, 32'h0);
    check({24'h0, endpoint_reset_bit_o}, 32'h0);
    // Suspend after a quiet bus, left again on traffic
    u_usbirq_host_model.go_quiet(1'b1);
    n = 0;
    while (suspended_o !== 1'b1 && n < 60) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check(32'(n >= IDLE - 2 && n <= IDLE + 3), 32'h1);
    rd(ADDR_IRQ_PENDING_VIEW, 32'h0100);
    check({31'h0, irq_o}, 32'h1);
    u_usbirq_host_model.go_quiet(1'b0);
    settle();
    check({31'h0, suspended_o}, 32'h0);
    wr(ADDR_IRQ_CLEAR, 32'h0100);
    settle();
    check({31'h0, irq_o}, 32'h0);
    finish_test();
  end
endmodule
